// >>> logic/buffered_dio_start_control.sv
// sample fifo and buffered dio start control with avalon-mm register slave
//
// Local design decisions: the address map and the Avalon-MM register port.
`include "dio_start_consts.svh"
`default_nettype none

// ====================================================================
// fifo with registered output stage
module dio_sample_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr_r;
    logic [AW-1:0]    rptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign push     = in_valid && in_ready;
    assign pop      = (count_r != '0) && (!out_valid || out_ready);

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_r  <= '0;
            rptr_r  <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= rptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data  <= mem[rptr_r];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule // dio_sample_fifo

// ====================================================================
// Summary of operation
// - count -1 moves exactly one buffer
// - count 0 runs until stopped
// - positive count moves exactly that many samples
// - buffer size comes from the configuration register
// - start trigger holds transfer until edge
// - trigger enable: 1 off (default), 2 on
// - trigger edge: 1 rising (default), 2 falling
// - zero trigger or handshake setting keeps the held value
// - handshake: 1 internal, 2 connector (default)
// - internal clock paces at programmed rate
// - rate in samples per second, -1 undefined
// - incoming error blocks start, passes through
// - error code 0 ok, negative fatal, positive warning
module buffered_dio_start_control
    import dio_start_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic [5:0]  ADDRESS,
    input  wire logic        READ,
    input  wire logic        WRITE,
    input  wire logic [31:0] WRITEDATA,
    input  wire logic [3:0]  BYTEENABLE,
    output logic      [31:0] READDATA,
    output logic             WAITREQUEST,
    input  wire logic [31:0] DIN,
    input  wire logic        HS_IN,
    input  wire logic        TRIG_IN,
    output logic      [31:0] SAMPLE_DATA,
    output logic             SAMPLE_VALID,
    input  wire logic        SAMPLE_READY,
    output logic             ACTIVE,
    output logic             DONE
);
    // ================================================================
    // register state
    run_state_t  state_r;
    logic [31:0] count_r;
    logic [1:0]  ttype_r;
    logic [1:0]  ten_r;
    logic [1:0]  tedge_r;
    logic [1:0]  hsrc_r;
    logic [31:0] rate_r;
    logic [31:0] bufsz_r;
    logic        err_stat_r;
    logic [31:0] err_code_r;
    logic [31:0] target_r;
    logic        forever_r;
    logic [31:0] xfers_r;
    logic        done_r;
    logic        req;
    logic        acc;
    logic [31:0] wmerge;

    // ================================================================
    // avalon slave: one wait cycle on every access
    assign req    = READ || WRITE;
    assign acc    = req && !WAITREQUEST;
    assign wmerge = be_merge(32'h0000_0000, WRITEDATA, BYTEENABLE);

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            WAITREQUEST <= 1'b1;
        end else begin
            WAITREQUEST <= !(req && WAITREQUEST);
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            READDATA <= 32'h0000_0000;
        end else if (READ && WAITREQUEST) begin
            case (ADDRESS)
                `OFS_COUNT:   READDATA <= count_r;
                `OFS_TRIG:    READDATA <= {22'h0, tedge_r, 2'h0, ten_r, 2'h0, ttype_r};
                `OFS_HSRC:    READDATA <= {30'h0, hsrc_r};
                `OFS_RATE:    READDATA <= rate_r;
                `OFS_BUFSZ:   READDATA <= bufsz_r;
                `OFS_ERRSTAT: READDATA <= {31'h0, err_stat_r};
                `OFS_ERRCODE: READDATA <= err_code_r;
                `OFS_STATUS:  READDATA <= {29'h0, done_r, state_r == ST_RUN, state_r == ST_ARMED};
                `OFS_XFERS:   READDATA <= xfers_r;
                default:      READDATA <= 32'h0000_0000;
            endcase
        end
    end

    // ================================================================
    // settings; a zero trigger or handshake field leaves the held one
    logic wr_trig;
    logic wr_hsrc;
    assign wr_trig = acc && WRITE && (ADDRESS == `OFS_TRIG);
    assign wr_hsrc = acc && WRITE && (ADDRESS == `OFS_HSRC) && BYTEENABLE[0];

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ttype_r <= `SEL_KEEP;
            ten_r   <= `TEN_OFF;
            tedge_r <= `TEDGE_RISE;
            hsrc_r  <= `HS_EXTERNAL;
        end else begin
            if (wr_trig && BYTEENABLE[0]) begin
                ttype_r <= keep_or_set(ttype_r, WRITEDATA[`TRIG_TYPE_LSB +: 2]);
                ten_r   <= keep_or_set(ten_r, WRITEDATA[`TRIG_EN_LSB +: 2]);
            end
            if (wr_trig && BYTEENABLE[1]) begin
                tedge_r <= keep_or_set(tedge_r, WRITEDATA[`TRIG_EDGE_LSB +: 2]);
            end
            if (wr_hsrc) begin
                hsrc_r <= keep_or_set(hsrc_r, WRITEDATA[1:0]);
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            count_r <= `COUNT_ONE_BUF;
            rate_r  <= `RATE_UNDEF;
            bufsz_r <= `BUFSZ_RST;
        end else if (acc && WRITE) begin
            if (ADDRESS == `OFS_COUNT) begin
                count_r <= be_merge(count_r, WRITEDATA, BYTEENABLE);
            end
            if (ADDRESS == `OFS_RATE) begin
                rate_r <= be_merge(rate_r, WRITEDATA, BYTEENABLE);
            end
            if (ADDRESS == `OFS_BUFSZ) begin
                bufsz_r <= be_merge(bufsz_r, WRITEDATA, BYTEENABLE);
            end
        end
    end

    // ================================================================
    // pin synchronisers; edges read only the second stage onward
    logic [31:0] din_s1, din_s2;
    logic        hs_s1, hs_s2, hs_d;
    logic        tr_s1, tr_s2, tr_d;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            din_s1 <= '0;
            din_s2 <= '0;
            {hs_s1, hs_s2, hs_d} <= 3'h0;
            {tr_s1, tr_s2, tr_d} <= 3'h0;
        end else begin
            din_s1 <= DIN;
            din_s2 <= din_s1;
            {hs_s1, hs_s2, hs_d} <= {HS_IN, hs_s1, hs_s2};
            {tr_s1, tr_s2, tr_d} <= {TRIG_IN, tr_s1, tr_s2};
        end
    end

    logic ext_tick;
    logic trig_fire;
    assign ext_tick  = hs_s2 && !hs_d;
    assign trig_fire = (tedge_r == `TEDGE_FALL) ? (!tr_s2 && tr_d) : (tr_s2 && !tr_d);

    // ================================================================
    // internal pacing: phase accumulator in samples per second
    logic [32:0] phase_r;
    logic [32:0] phase_sum;
    logic        int_tick;
    logic        rate_ok;
    assign rate_ok   = !rate_r[31] && (rate_r != 32'h0000_0000);
    assign phase_sum = phase_r + {1'b0, rate_r};
    assign int_tick  = (state_r == ST_RUN) && rate_ok && (phase_sum >= {1'b0, `CLK_HZ});

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            phase_r <= '0;
        end else if (state_r != ST_RUN || !rate_ok) begin
            phase_r <= '0;
        end else if (int_tick) begin
            // rates above the clock saturate at one sample per cycle
            phase_r <= (phase_sum >= {`CLK_HZ, 1'b0}) ? 33'h0 : phase_sum - {1'b0, `CLK_HZ};
        end else begin
            phase_r <= phase_sum;
        end
    end

    // ================================================================
    // transfer path; one tick waiting on a full fifo is held, further ticks until it is pushed are lost
    logic tick;
    logic pend_r;
    logic push;
    logic fifo_ready;
    assign tick = (hsrc_r == `HS_INTERNAL) ? int_tick : ext_tick;
    assign push = (state_r == ST_RUN) && (tick || pend_r) && fifo_ready;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= (state_r == ST_RUN) && (tick || pend_r) && !fifo_ready;
        end
    end

    dio_sample_fifo #(.WIDTH(32), .DEPTH(32)) u_fifo (
        .clk       (CLOCK),
        .rst_n     (RST_N),
        .in_data   (din_s2),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .out_data  (SAMPLE_DATA),
        .out_valid (SAMPLE_VALID),
        .out_ready (SAMPLE_READY)
    );

    // ================================================================
    // start, stop and completion
    logic start_req;
    logic stop_req;
    logic start_ok;
    logic last_push;
    logic count_bad;
    assign start_req = acc && WRITE && (ADDRESS == `OFS_CTRL) && wmerge[`CTRL_START_BIT];
    assign stop_req  = acc && WRITE && (ADDRESS == `OFS_CTRL) && wmerge[`CTRL_STOP_BIT];
    assign count_bad = count_r[31] && (count_r != `COUNT_ONE_BUF);
    assign start_ok  = start_req && !err_stat_r && (state_r == ST_IDLE) && !count_bad
                       && !(hsrc_r == `HS_INTERNAL && !rate_ok);
    assign last_push = push && !forever_r && (xfers_r + 32'h0000_0001 >= target_r);

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start_ok) begin
                        state_r <= (ten_r == `TEN_ON && ttype_r == `TTYPE_START)
                                   ? ST_ARMED : ST_RUN;
                    end
                end
                ST_ARMED: begin
                    if (stop_req) begin
                        state_r <= ST_IDLE;
                    end else if (trig_fire) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (stop_req || last_push) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            target_r  <= 32'h0000_0000;
            forever_r <= 1'b0;
            xfers_r   <= 32'h0000_0000;
            done_r    <= 1'b0;
        end else if (start_ok) begin
            target_r  <= (count_r == `COUNT_ONE_BUF) ? bufsz_r : count_r;
            forever_r <= (count_r == `COUNT_FOREVER);
            xfers_r   <= 32'h0000_0000;
            done_r    <= 1'b0;
        end else if (push) begin
            xfers_r <= xfers_r + 32'h0000_0001;
            done_r  <= last_push;
        end
    end

    // ================================================================
    // error in, error out: an error already set passes unchanged
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            err_stat_r <= 1'b0;
            err_code_r <= `ERR_NONE;
        end else if (acc && WRITE && ADDRESS == `OFS_ERRSTAT && BYTEENABLE[0]) begin
            err_stat_r <= WRITEDATA[0];
        end else if (acc && WRITE && ADDRESS == `OFS_ERRCODE) begin
            err_code_r <= be_merge(err_code_r, WRITEDATA, BYTEENABLE);
        end else if (start_req && !err_stat_r) begin
            if (count_bad) begin
                err_stat_r <= 1'b1;
                err_code_r <= `ERR_BAD_COUNT;
            end else if (hsrc_r == `HS_INTERNAL && !rate_ok) begin
                err_stat_r <= 1'b1;
                err_code_r <= `ERR_RATE_UNDEF;
            end else if (state_r != ST_IDLE) begin
                err_code_r <= `WARN_BUSY;
            end else begin
                err_code_r <= `ERR_NONE;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ACTIVE <= 1'b0;
            DONE   <= 1'b0;
        end else begin
            ACTIVE <= (state_r != ST_IDLE);
            DONE   <= done_r;
        end
    end

    // ================================================================
    // checks
    sequence s_start_idle;
        start_ok && (state_r == ST_IDLE);
    endsequence

    chk_trig_hold: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (state_r == ST_ARMED) && !trig_fire |=> !push)
        else $error("transfer moved before the start trigger");
    chk_one_buffer: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_start_idle and (count_r == `COUNT_ONE_BUF) |=> target_r == $past(bufsz_r) && !forever_r)
        else $error("default count did not select one buffer");
    chk_run_forever: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (state_r == ST_RUN) && forever_r && !stop_req |=> state_r == ST_RUN)
        else $error("continuous transfer ended without stop");
    chk_count_done: assert property (@(posedge CLOCK) disable iff (!RST_N)
        push && !forever_r && (xfers_r == target_r - 32'h0000_0001)
        |=> state_r == ST_IDLE && done_r && xfers_r == target_r)
        else $error("counted transfer did not finish on its last sample");
    chk_keep_zero: assert property (@(posedge CLOCK) disable iff (!RST_N)
        wr_hsrc && WRITEDATA[1:0] == 2'h0 |=> $stable(hsrc_r))
        else $error("zero handshake setting changed the held value");
    chk_int_pace: assert property (@(posedge CLOCK) disable iff (!RST_N)
        push && !pend_r && hsrc_r == `HS_INTERNAL |-> int_tick)
        else $error("internal pacing moved a sample without a rate tick");
    chk_err_block: assert property (@(posedge CLOCK) disable iff (!RST_N)
        start_req && err_stat_r && state_r == ST_IDLE |=> state_r == ST_IDLE && $stable(err_code_r))
        else $error("start acted despite incoming error");
    chk_fatal_neg: assert property (@(posedge CLOCK) disable iff (!RST_N)
        start_req && !err_stat_r && hsrc_r == `HS_INTERNAL && !rate_ok && !count_bad
        |=> err_stat_r && err_code_r[31])
        else $error("undefined rate start not reported as fatal");
    chk_trig_off: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_start_idle and (ten_r != `TEN_ON) |=> state_r == ST_RUN)
        else $error("disabled trigger did not start at once");
    chk_bus_answer: assert property (@(posedge CLOCK) disable iff (!RST_N)
        req && WAITREQUEST |=> !WAITREQUEST ##1 WAITREQUEST)
        else $error("bus answer not one cycle after request");
endmodule // buffered_dio_start_control
`default_nettype wire

// >>> logic/dio_start_consts.svh
// register map, field positions, reset values and timing for the buffered dio start control
`ifndef DIO_START_CONSTS_SVH
`define DIO_START_CONSTS_SVH
// ====================================================================
// register offsets (byte addresses)
`define OFS_CTRL       6'h00
`define OFS_COUNT      6'h04
`define OFS_TRIG       6'h08
`define OFS_HSRC       6'h0C
`define OFS_RATE       6'h10
`define OFS_BUFSZ      6'h14
`define OFS_ERRSTAT    6'h18
`define OFS_ERRCODE    6'h1C
`define OFS_STATUS     6'h20
`define OFS_XFERS      6'h24
// ====================================================================
// field positions
`define CTRL_START_BIT 0
`define CTRL_STOP_BIT  1
`define TRIG_TYPE_LSB  0
`define TRIG_EN_LSB    4
`define TRIG_EDGE_LSB  8
// ====================================================================
// setting encodings, 0 always means keep
`define SEL_KEEP       2'h0
`define TTYPE_START    2'h1
`define TEN_OFF        2'h1
`define TEN_ON         2'h2
`define TEDGE_RISE     2'h1
`define TEDGE_FALL     2'h2
`define HS_INTERNAL    2'h1
`define HS_EXTERNAL    2'h2
// ====================================================================
// reset values, special counts and error codes
`define COUNT_ONE_BUF  32'hFFFF_FFFF
`define COUNT_FOREVER  32'h0000_0000
`define RATE_UNDEF     32'hFFFF_FFFF
`define BUFSZ_RST      32'h0000_0400
`define ERR_NONE       32'h0000_0000
`define ERR_RATE_UNDEF 32'hFFFF_FFF6
`define ERR_BAD_COUNT  32'hFFFF_FFF5
`define WARN_BUSY      32'h0000_0001
// ====================================================================
// timing: clock period in ns, rate accumulator modulus in cycles per second
`define CLK_PERIOD_NS  32'h0000_0028
`define CLK_HZ         (32'h3B9A_CA00 / `CLK_PERIOD_NS)
`endif

// >>> logic/dio_start_pkg.sv
// types and shared helpers for the buffered dio start control
`default_nettype none
package dio_start_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} run_state_t;
    // a zero field keeps the held setting
    function automatic logic [1:0] keep_or_set(input logic [1:0] held, input logic [1:0] req);
        keep_or_set = (req == 2'h0) ? held : req;
    endfunction
    // merge a write word into a register under byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            be_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction
endpackage
`default_nettype wire

// >>> verification/buffered_dio_start_control_bench.sv
// self-checking bench for the buffered dio start control
`include "dio_start_consts.svh"
`default_nettype none
module buffered_dio_start_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, rst_n, rd, wr, srdy, sval, act, done, wreq, hs, trig, stall;
    logic [5:0]  adr;
    logic [31:0] wdat, rdat, sdat, din, got;
    logic [31:0] expq[$];
    int          n_mismatch, tests_run, seed;

    buffered_dio_start_control uut (.CLOCK(clock), .RST_N(rst_n), .ADDRESS(adr), .READ(rd),
        .WRITE(wr), .WRITEDATA(wdat), .BYTEENABLE(4'hF), .READDATA(rdat), .WAITREQUEST(wreq),
        .DIN(din), .HS_IN(hs), .TRIG_IN(trig), .SAMPLE_DATA(sdat), .SAMPLE_VALID(sval),
        .SAMPLE_READY(srdy), .ACTIVE(act), .DONE(done));
    dio_edge_source far (.clk(clock), .din(din), .hs(hs), .trig(trig));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // ====================================================================
    // checking
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t register %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_sample(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t sample %h expected %h", $time, g, e);
        end
    endtask
    always @(posedge clock) begin
        if (rst_n === 1'b1 && sval === 1'b1 && srdy === 1'b1) begin
            if (expq.size() == 0) begin
                n_mismatch++;
                $display("[ERR] %0t unexpected sample %h", $time, sdat);
            end else chk_sample(sdat, expq.pop_front());
        end
    end
    // random stalls on the drain side
    always @(posedge clock) srdy <= !stall && ($random(seed) % 4 != 0);
    task automatic close_out;
        if (expq.size() != 0) begin
            n_mismatch++;
            $display("[ERR] %0t %0d samples never seen", $time, expq.size());
        end
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ====================================================================
    // stimulus
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clock);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        // no assumed latency: a missing answer is caught by the watchdog
        do begin
            @(posedge clock);
        end while (wreq !== 1'b0);
        got = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk_reg(got, e);
    endtask
    task automatic ticks(input int n, input logic keep);
        logic [31:0] d;
        repeat (n) begin
            d = $random(seed);
            if (keep) expq.push_back(d);
            far.tick(d);
        end
    endtask
    task automatic wait_q;
        int n;
        n = 0;
        while (expq.size() != 0 && n < 3000) begin
            @(posedge clock);
            n++;
        end
        repeat (6) @(posedge clock);
    endtask
    initial begin
        repeat (60000) @(posedge clock);
        n_mismatch++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out;
    end
    initial begin
        seed = 32'h0a8c_4148;
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        adr = 6'h00;
        wdat = 32'h0000_0000;
        stall = 1'b0;
        srdy = 1'b0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rdchk(`OFS_COUNT, `COUNT_ONE_BUF);
        rdchk(`OFS_TRIG, 32'h0000_0110);
        rdchk(`OFS_HSRC, 32'h0000_0002);
        rdchk(`OFS_RATE, `RATE_UNDEF);
        rdchk(`OFS_BUFSZ, `BUFSZ_RST);
        rdchk(`OFS_ERRCODE, `ERR_NONE);
        rdchk(6'h3C, 32'h0000_0000);
        bus(1'b1, `OFS_TRIG, 32'h0000_0000);
        rdchk(`OFS_TRIG, 32'h0000_0110);
        bus(1'b1, `OFS_HSRC, 32'h0000_0000);
        rdchk(`OFS_HSRC, 32'h0000_0002);
        // counted run, trigger off: extra tick must not show up
        bus(1'b1, `OFS_COUNT, 32'h0000_0003);
        bus(1'b1, `OFS_CTRL, 32'h0000_0001);
        ticks(3, 1'b1);
        ticks(1, 1'b0);
        wait_q;
        chk_reg({30'h0000_0000, act, done}, 32'h0000_0001);
        // falling-edge trigger, then rising again: a rise and an early tick are ignored
        bus(1'b1, `OFS_COUNT, 32'h0000_0002);
        bus(1'b1, `OFS_TRIG, 32'h0000_0221);
        bus(1'b1, `OFS_CTRL, 32'h0000_0001);
        far.trig_to(1'b1);
        ticks(1, 1'b0);
        rdchk(`OFS_STATUS, 32'h0000_0001);
        far.trig_to(1'b0);
        ticks(2, 1'b1);
        wait_q;
        bus(1'b1, `OFS_TRIG, 32'h0000_0100);
        rdchk(`OFS_TRIG, 32'h0000_0121);
        bus(1'b1, `OFS_CTRL, 32'h0000_0001);
        far.trig_to(1'b1);
        ticks(2, 1'b1);
        wait_q;
        bus(1'b1, `OFS_TRIG, 32'h0000_0010);
        // errors: bad count, blocked start, undefined rate
        bus(1'b1, `OFS_COUNT, 32'hFFFF_FFFE);
        bus(1'b1, `OFS_CTRL, 32'h0000_0001);
        rdchk(`OFS_ERRCODE, `ERR_BAD_COUNT);
        rdchk(`OFS_ERRSTAT, 32'h0000_0001);
        bus(1'b1, `OFS_COUNT, 32'h0000_0001);
        bus(1'b1, `OFS_CTRL, 32'h0000_0001);
        ticks(1, 1'b0);
        rdchk(`OFS_ERRCODE, `ERR_BAD_COUNT);
        rdchk(`OFS_STATUS, 32'h0000_0004);
        bus(1'b1, `OFS_ERRSTAT, 32'h0000_0000);
        bus(1'b1, `OFS_HSRC, 32'h0000_0001);
        bus(1'b1, `OFS_CTRL, 32'h0000_0001);
        rdchk(`OFS_ERRCODE, `ERR_RATE_UNDEF);
        bus(1'b1, `OFS_ERRSTAT, 32'h0000_0000);
        // continuous run past a short buffer, busy warning, then stop
        bus(1'b1, `OFS_HSRC, 32'h0000_0002);
        bus(1'b1, `OFS_BUFSZ, 32'h0000_0004);
        bus(1'b1, `OFS_COUNT, 32'h0000_0000);
        bus(1'b1, `OFS_CTRL, 32'h0000_0001);
        ticks(6, 1'b1);
        bus(1'b1, `OFS_CTRL, 32'h0000_0001);
        rdchk(`OFS_ERRCODE, `WARN_BUSY);
        wait_q;
        rdchk(`OFS_STATUS, 32'h0000_0002);
        chk_reg({31'h0000_0000, act}, 32'h0000_0001);
        bus(1'b1, `OFS_CTRL, 32'h0000_0002);
        ticks(1, 1'b0);
        rdchk(`OFS_STATUS, 32'h0000_0000);
        // one buffer of the configured size
        bus(1'b1, `OFS_COUNT, `COUNT_ONE_BUF);
        bus(1'b1, `OFS_CTRL, 32'h0000_0001);
        ticks(4, 1'b1);
        ticks(1, 1'b0);
        wait_q;
        rdchk(`OFS_STATUS, 32'h0000_0004);
        // internal clock at full rate into a stalled fifo, then drain
        stall <= 1'b1;
        far.din <= 32'h5A5A_0F0F;
        repeat (40) expq.push_back(32'h5A5A_0F0F);
        bus(1'b1, `OFS_HSRC, 32'h0000_0001);
        bus(1'b1, `OFS_RATE, 32'h017D_7840);
        bus(1'b1, `OFS_COUNT, 32'h0000_0028);
        bus(1'b1, `OFS_CTRL, 32'h0000_0001);
        repeat (60) @(posedge clock);
        rdchk(`OFS_STATUS, 32'h0000_0002);
        stall <= 1'b0;
        wait_q;
        rdchk(`OFS_XFERS, 32'h0000_0028);
        rdchk(`OFS_STATUS, 32'h0000_0004);
        close_out;
    end
endmodule // buffered_dio_start_control_bench
`default_nettype wire

// >>> verification/dio_edge_source.sv
// connector-side model: data pins, handshake line and start trigger
`default_nettype none
module dio_edge_source (
    input  wire logic        clk,
    output logic      [31:0] din,
    output logic             hs,
    output logic             trig
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        din = 32'h0000_0000;
        hs = 1'b0;
        trig = 1'b0;
    end
    // ====================================================================
    // one word per handshake; data held around the edge for the synchroniser
    task automatic tick(input logic [31:0] d);
        din <= d;
        repeat (3) @(posedge clk);
        hs <= 1'b1;
        repeat (4) @(posedge clk);
        hs <= 1'b0;
        din <= ~d; // hold time over, old value gone
        @(posedge clk);
    endtask
    task automatic trig_to(input logic lvl);
        trig <= lvl;
        repeat (4) @(posedge clk);
    endtask
endmodule // dio_edge_source
`default_nettype wire
